// [design/tbl_pkg.sv]
// Package with register map, field layout and shared types of the table access unit
package tbl_pkg;
  // APB register byte addresses
  localparam logic [7:0] LatchAddr    = 8'h00;
  localparam logic [7:0] PtrLowAddr   = 8'h04;
  localparam logic [7:0] PtrHighAddr  = 8'h08;
  localparam logic [7:0] PtrUpperAddr = 8'h0C;
  localparam logic [7:0] ControlAddr  = 8'h10;
  localparam logic [7:0] CommandAddr  = 8'h14;
  // Control register bit positions
  localparam int ReadStrobeBit   = 0;
  localparam int SpaceSelectBit  = 7;
  // Command register fields
  localparam int CmdGoBit  = 4;
  localparam int CmdWriteBit = 2;
  localparam int CmdOpLsb  = 0;
  // Pointer geometry
  localparam int PtrWidth     = 22;
  localparam int LowPtrWidth  = 21;
  localparam int HoldSelWidth = 3;
  localparam int EraseLsb     = 6;
  localparam int WriteLsb     = 3;
  // Reset values
  localparam logic [7:0]  LatchReset = 8'h00;
  localparam logic [21:0] PtrReset   = 22'h000000;

  // Table instruction pointer modes
  typedef enum logic [1:0] {
    PtrKeep,
    PtrPostInc,
    PtrPostDec,
    PtrPreInc
  } ptr_mode_e;

  // Request toward program or configuration memory
  typedef struct packed {
    logic        readEn;
    logic [21:0] readAddr;
    logic        holdWrEn;
    logic [2:0]  holdSel;
    logic [7:0]  holdData;
    logic [18:0] writeBlock;
    logic [15:0] eraseBlock;
  } mem_req_s;
endpackage

// [design/program_memory_table_access.sv]
// Table pointer, table latch and read strobe logic with an APB register slave
`timescale 1ns/1ps
// Summary of operation
// RQ1: Read strobe reads once, then self-clears.
// RQ2: Software can only set read strobe.
// RQ3: Strobe refused while program space selected.
// RQ4: Eight-bit table latch holds moved byte.
// RQ5: Pointer joins upper, high, low: 22 bits.
// RQ6: Low 21 bits address program bytes.
// RQ7: Bit 21 reaches ID and configuration space.
// RQ8: Auto updates touch only low 21 bits.
// RQ9: Table read uses all 22 pointer bits.
// RQ10: Pointer bits 2:0 pick holding register.
// RQ11: Bits 21:3 pick 8-byte write block.
// RQ12: Bits 21:6 pick 64-byte erase block.
// RQ13: Plain form keeps pointer unchanged.
// RQ14: Post-increment: access then add one.
// RQ15: Post-decrement: access then subtract one.
// RQ16: Pre-increment: add one, then access.
// RQ17: One byte per table read.
// RQ18: Pointer bit 0 picks word byte.
// RQ19: Low field wraps modulo two to 21.
module program_memory_table_access (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Program memory word read port, combinational, same cycle
  output tbl_pkg::mem_req_s       memReq,
  input  wire logic [15:0]        memWord,
  // Flash sequencer hooks
  output logic                    configSpace,
  output logic                    readBusy
);

  logic [7:0]  latch_q;
  logic [21:0] ptr_q;
  logic        strobe_q;
  logic        spaceSel_q;
  logic [21:0] accessAddr;
  logic [20:0] lowInc;
  logic [20:0] lowDec;
  logic        wrEn;
  logic        rdEn;
  logic        cmdGo;
  logic        cmdWrite;
  tbl_pkg::ptr_mode_e cmdMode;
  logic        tableRead;
  logic        tableWrite;
  logic        strobeRead;
  logic [7:0]  readByte;

  // APB decode; zero wait states
  assign wrEn     = psel && penable && pwrite;
  assign rdEn     = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign cmdGo    = wrEn && paddr == tbl_pkg::CommandAddr && pwdata[tbl_pkg::CmdGoBit];
  assign cmdWrite = pwdata[tbl_pkg::CmdWriteBit];
  assign cmdMode  = tbl_pkg::ptr_mode_e'(pwdata[tbl_pkg::CmdOpLsb +: 2]);
  assign tableRead  = cmdGo && !cmdWrite;
  assign tableWrite = cmdGo && cmdWrite;
  assign strobeRead = strobe_q;

  // Unmapped addresses answer with an error
  always_comb begin
    case (paddr)
      tbl_pkg::LatchAddr, tbl_pkg::PtrLowAddr, tbl_pkg::PtrHighAddr,
      tbl_pkg::PtrUpperAddr, tbl_pkg::ControlAddr, tbl_pkg::CommandAddr: pslverr = 1'b0;
      default: pslverr = psel && penable;
    endcase
  end

  // Low field wraps inside 21 bits, top bit untouched
  assign lowInc = ptr_q[20:0] + 21'h000001; // [RQ8] [RQ19]
  assign lowDec = ptr_q[20:0] - 21'h000001; // [RQ8] [RQ19]

  // Access address: pre-increment uses the updated pointer
  always_comb begin
    accessAddr = ptr_q; // [RQ14] [RQ15]
    if (cmdGo && cmdMode == tbl_pkg::PtrPreInc) begin
      accessAddr = {ptr_q[21], lowInc}; // [RQ16]
    end
  end

  // Byte select out of the fetched word
  assign readByte = accessAddr[0] ? memWord[15:8] : memWord[7:0]; // [RQ18]

  // Request to memory: read, holding register write, block addresses
  always_comb begin
    memReq            = '0;
    memReq.readEn     = tableRead || strobeRead;
    memReq.readAddr   = accessAddr; // [RQ9] [RQ7] [RQ6]
    memReq.holdWrEn   = tableWrite;
    memReq.holdSel    = accessAddr[2:0]; // [RQ10]
    memReq.holdData   = latch_q;
    memReq.writeBlock = ptr_q[21:3]; // [RQ11]
    memReq.eraseBlock = ptr_q[21:6]; // [RQ12]
  end

  assign configSpace = ptr_q[21]; // [RQ7]
  assign readBusy    = strobe_q;

  // Table latch: one byte per read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      latch_q <= tbl_pkg::LatchReset;
    end else if (tableRead || strobeRead) begin
      latch_q <= readByte; // [RQ17] [RQ4]
    end else if (wrEn && paddr == tbl_pkg::LatchAddr) begin
      latch_q <= pwdata[7:0]; // [RQ4]
    end
  end

  // Pointer: byte writes and table instruction updates
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ptr_q <= tbl_pkg::PtrReset;
    end else if (cmdGo) begin
      case (cmdMode)
        tbl_pkg::PtrKeep:    ptr_q <= ptr_q; // [RQ13]
        tbl_pkg::PtrPostInc: ptr_q <= {ptr_q[21], lowInc}; // [RQ14]
        tbl_pkg::PtrPostDec: ptr_q <= {ptr_q[21], lowDec}; // [RQ15]
        tbl_pkg::PtrPreInc:  ptr_q <= {ptr_q[21], lowInc}; // [RQ16]
        default:             ptr_q <= ptr_q;
      endcase
    end else if (wrEn) begin
      case (paddr)
        tbl_pkg::PtrLowAddr:   ptr_q[7:0]   <= pwdata[7:0]; // [RQ5]
        tbl_pkg::PtrHighAddr:  ptr_q[15:8]  <= pwdata[7:0]; // [RQ5]
        tbl_pkg::PtrUpperAddr: ptr_q[21:16] <= pwdata[5:0]; // [RQ5]
        default:               ptr_q        <= ptr_q;
      endcase
    end
  end

  // Space select bit, plain read/write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      spaceSel_q <= 1'b0;
    end else if (wrEn && paddr == tbl_pkg::ControlAddr) begin
      spaceSel_q <= pwdata[tbl_pkg::SpaceSelectBit];
    end
  end

  // Read strobe: set-only by software, cleared after one cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b0;
    end else if (strobe_q) begin
      strobe_q <= 1'b0; // [RQ1]
    end else if (wrEn && paddr == tbl_pkg::ControlAddr && pwdata[tbl_pkg::ReadStrobeBit]
                 && !spaceSel_q && !pwdata[tbl_pkg::SpaceSelectBit]) begin
      strobe_q <= 1'b1; // [RQ2] [RQ3]
    end
  end

  // Read data mux, registered in the setup cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (rdEn) begin
      case (paddr)
        tbl_pkg::LatchAddr:    prdata <= {24'h000000, latch_q};
        tbl_pkg::PtrLowAddr:   prdata <= {24'h000000, ptr_q[7:0]};
        tbl_pkg::PtrHighAddr:  prdata <= {24'h000000, ptr_q[15:8]};
        tbl_pkg::PtrUpperAddr: prdata <= {26'h0000000, ptr_q[21:16]};
        tbl_pkg::ControlAddr:  prdata <= {24'h000000, spaceSel_q, 6'h00, strobe_q};
        default:               prdata <= 32'h00000000;
      endcase
    end
  end

  // Strobe self-clears one cycle after being set
  strobe_clear_a: assert property (@(posedge clock) disable iff (rst) // [RQ1]
    strobe_q |=> !strobe_q)
    else $error("read strobe stayed set");

  // Strobe rises only after a software write with the strobe bit set
  strobe_cause_a: assert property (@(posedge clock) disable iff (rst) // [RQ2]
    $rose(strobe_q) |-> $past(wrEn) && $past(pwdata[tbl_pkg::ReadStrobeBit]))
    else $error("strobe set without software write");

  // Strobe refused while program space is selected
  strobe_refuse_a: assert property (@(posedge clock) disable iff (rst) // [RQ3]
    $rose(strobe_q) |-> !$past(spaceSel_q))
    else $error("strobe set with space select high");

  // Top pointer bit kept by table updates
  top_bit_kept_a: assert property (@(posedge clock) disable iff (rst) // [RQ8]
    cmdGo |=> ptr_q[21] == $past(ptr_q[21]))
    else $error("table update changed top pointer bit");

  // Access made at the pointer as it stood
  sequence accessAtPointer;
    memReq.readAddr == ptr_q;
  endsequence

  // Access made one past the pointer, top bit kept
  sequence accessPastPointer;
    memReq.readAddr == {ptr_q[21], lowInc};
  endsequence

  // Low field one higher than before the edge
  sequence lowSteppedUp;
    ptr_q[20:0] == $past(lowInc);
  endsequence

  // Low field one lower than before the edge
  sequence lowSteppedDown;
    ptr_q[20:0] == $past(lowDec);
  endsequence

  // Pointer equals the address just used
  sequence pointerAtLastAccess;
    ptr_q == $past(memReq.readAddr);
  endsequence

  // Post increment wraps in the low field
  post_inc_a: assert property (@(posedge clock) disable iff (rst) // [RQ14]
    cmdGo && cmdMode == tbl_pkg::PtrPostInc |-> accessAtPointer ##1 lowSteppedUp)
    else $error("post increment wrong");

  // Post decrement
  post_dec_a: assert property (@(posedge clock) disable iff (rst) // [RQ15]
    cmdGo && cmdMode == tbl_pkg::PtrPostDec |-> accessAtPointer ##1 lowSteppedDown)
    else $error("post decrement wrong");

  // Pre increment accesses the new address
  pre_inc_a: assert property (@(posedge clock) disable iff (rst) // [RQ16]
    cmdGo && cmdMode == tbl_pkg::PtrPreInc |-> accessPastPointer ##1 pointerAtLastAccess)
    else $error("pre increment wrong");

  // Plain form keeps pointer
  keep_ptr_a: assert property (@(posedge clock) disable iff (rst) // [RQ13]
    cmdGo && cmdMode == tbl_pkg::PtrKeep |=> $stable(ptr_q))
    else $error("plain form moved pointer");

  // Latch takes the selected byte of the word
  byte_sel_a: assert property (@(posedge clock) disable iff (rst) // [RQ18]
    tableRead |=> latch_q == ($past(accessAddr[0]) ? $past(memWord[15:8])
                                                   : $past(memWord[7:0])))
    else $error("latch byte select wrong");

  // Software write lands in the latch
  latch_load_a: assert property (@(posedge clock) disable iff (rst) // [RQ4]
    wrEn && paddr == tbl_pkg::LatchAddr && !strobeRead
      |=> latch_q == $past(pwdata[7:0]))
    else $error("latch write lost");

  // Latch moves only on a read or a software write
  latch_hold_a: assert property (@(posedge clock) disable iff (rst) // [RQ17]
    !memReq.readEn && !(wrEn && paddr == tbl_pkg::LatchAddr) |=> $stable(latch_q))
    else $error("latch changed without cause");

  // Latch read back over the bus
  latch_readback_a: assert property (@(posedge clock) disable iff (rst) // [RQ4]
    rdEn && paddr == tbl_pkg::LatchAddr |=> prdata == {24'h000000, $past(latch_q)})
    else $error("latch read back wrong");

  // Low pointer byte written alone
  ptr_low_write_a: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    wrEn && paddr == tbl_pkg::PtrLowAddr
      |=> ptr_q == {$past(ptr_q[21:8]), $past(pwdata[7:0])})
    else $error("low pointer byte write wrong");

  // High pointer byte written alone
  ptr_high_write_a: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    wrEn && paddr == tbl_pkg::PtrHighAddr
      |=> ptr_q == {$past(ptr_q[21:16]), $past(pwdata[7:0]), $past(ptr_q[7:0])})
    else $error("high pointer byte write wrong");

  // Upper pointer bits written alone
  ptr_upper_write_a: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    wrEn && paddr == tbl_pkg::PtrUpperAddr
      |=> ptr_q == {$past(pwdata[5:0]), $past(ptr_q[15:0])})
    else $error("upper pointer write wrong");

  // Upper pointer bits read back
  upper_readback_a: assert property (@(posedge clock) disable iff (rst) // [RQ5]
    rdEn && paddr == tbl_pkg::PtrUpperAddr |=> prdata == {26'h0, $past(ptr_q[21:16])})
    else $error("upper pointer read back wrong");

  // Pointer stands still without a command or a write
  ptr_idle_a: assert property (@(posedge clock) disable iff (rst) // [RQ13]
    !cmdGo && !wrEn |=> $stable(ptr_q))
    else $error("pointer moved while idle");

  // Reads other than pre increment use the full pointer
  read_addr_a: assert property (@(posedge clock) disable iff (rst) // [RQ9] [RQ6]
    memReq.readEn && !(cmdGo && cmdMode == tbl_pkg::PtrPreInc)
      |-> memReq.readAddr == ptr_q)
    else $error("read address not the pointer");

  // Every read keeps the space given by the top bit
  read_space_a: assert property (@(posedge clock) disable iff (rst) // [RQ7] [RQ8]
    memReq.readEn |-> memReq.readAddr[21] == ptr_q[21])
    else $error("read left its space");

  // Configuration space flag moves only by an upper write
  config_hold_a: assert property (@(posedge clock) disable iff (rst) // [RQ7]
    !(wrEn && paddr == tbl_pkg::PtrUpperAddr) |=> $stable(configSpace))
    else $error("space flag moved without upper write");

  // Table write hands latch byte to the selected holding register
  hold_sel_a: assert property (@(posedge clock) disable iff (rst) // [RQ10]
    tableWrite && cmdMode != tbl_pkg::PtrPreInc
      |-> memReq.holdWrEn && memReq.holdSel == ptr_q[2:0] && memReq.holdData == latch_q)
    else $error("holding register select wrong");

  // Pre increment write selects by the stepped pointer
  hold_sel_pre_a: assert property (@(posedge clock) disable iff (rst) // [RQ10]
    tableWrite && cmdMode == tbl_pkg::PtrPreInc |-> memReq.holdSel == lowInc[2:0])
    else $error("pre increment holding select wrong");

  // Never a read and a holding write at once
  no_hold_read_a: assert property (@(posedge clock) disable iff (rst) // [RQ17]
    !(memReq.readEn && memReq.holdWrEn))
    else $error("read and holding write together");

  // Block addresses follow only pointer changes
  blocks_hold_a: assert property (@(posedge clock) disable iff (rst) // [RQ11] [RQ12]
    !cmdGo && !wrEn |=> $stable(memReq.writeBlock) && $stable(memReq.eraseBlock))
    else $error("block address moved while idle");

  // Increment past the top of the low field wraps to zero
  inc_wrap_a: assert property (@(posedge clock) disable iff (rst) // [RQ19]
    cmdGo && cmdMode == tbl_pkg::PtrPostInc && ptr_q[20:0] == 21'h1FFFFF
      |=> ptr_q[20:0] == 21'h000000)
    else $error("increment did not wrap");

  // Decrement below zero wraps to the top of the low field
  dec_wrap_a: assert property (@(posedge clock) disable iff (rst) // [RQ19]
    cmdGo && cmdMode == tbl_pkg::PtrPostDec && ptr_q[20:0] == 21'h000000
      |=> ptr_q[20:0] == 21'h1FFFFF)
    else $error("decrement did not wrap");

  // Strobe cycle fetches at the pointer
  strobe_fetch_a: assert property (@(posedge clock) disable iff (rst) // [RQ1] [RQ9]
    strobe_q |-> memReq.readEn && memReq.readAddr == ptr_q)
    else $error("strobe read not issued");

  // Strobe read loads the selected byte
  strobe_byte_a: assert property (@(posedge clock) disable iff (rst) // [RQ18]
    strobe_q |=> latch_q == ($past(ptr_q[0]) ? $past(memWord[15:8])
                                             : $past(memWord[7:0])))
    else $error("strobe read byte wrong");

  // Write selecting program space never starts a read
  strobe_block_a: assert property (@(posedge clock) disable iff (rst) // [RQ3]
    wrEn && paddr == tbl_pkg::ControlAddr && pwdata[tbl_pkg::SpaceSelectBit]
      |=> !strobe_q)
    else $error("strobe set with space select written");

  // Writing zero to the strobe never starts a read
  strobe_zero_a: assert property (@(posedge clock) disable iff (rst) // [RQ2]
    wrEn && paddr == tbl_pkg::ControlAddr && !pwdata[tbl_pkg::ReadStrobeBit]
      |=> !strobe_q)
    else $error("zero write started a read");

  // Strobe state read back over the bus
  strobe_readback_a: assert property (@(posedge clock) disable iff (rst) // [RQ1]
    rdEn && paddr == tbl_pkg::ControlAddr
      |=> prdata[tbl_pkg::ReadStrobeBit] == $past(strobe_q))
    else $error("strobe read back wrong");

  // Table read fetches for one cycle only
  read_pulse_a: assert property (@(posedge clock) disable iff (rst) // [RQ17]
    tableRead |=> !memReq.readEn)
    else $error("table read fetched twice");

endmodule

// [verification/program_memory_model.sv]
// Program memory model answering word reads in the same cycle
`timescale 1ns/1ps
module program_memory_model (
  // Clock
  input  wire logic              clock,
  // Word read port
  input  wire tbl_pkg::mem_req_s memReq,
  output logic [15:0]            memWord
);
  logic [15:0] junk_q = 16'hA5C3;
  // Junk that changes every cycle while no read is asked for
  always_ff @(posedge clock) begin
    junk_q <= ~junk_q ^ 16'h3C96;
  end
  // Word contents; bit 21 selects a different space
  always_comb begin
    if (memReq.readEn) begin
      memWord = {memReq.readAddr[8:1] ^ 8'h5A, memReq.readAddr[16:9] ^ memReq.readAddr[21:14]};
    end else begin
      memWord = junk_q;
    end
  end
endmodule

// [verification/test_program_memory_table_access.sv]
// Self-checking testbench of the table access unit
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module test_program_memory_table_access;
  logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, configSpace, readBusy, lastErr;
  logic [15:0] memWord;
  tbl_pkg::mem_req_s memReq, lastReq;
  int miscompares = 0, checked = 0, busyCycles = 0, readEns = 0, b0, e0;
  int seed = 32'hD3A67F22;
  logic [21:0] p, a, q;
  logic [7:0] b;
  logic [7:0] corner_addr [4] = '{8'h00, 8'h04, 8'h08, 8'h0C};
  logic [21:0] corner [4] = '{22'h000001, 22'h1FFFFF, 22'h200000, 22'h3FFFFF};
  program_memory_table_access dut_u (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .memReq(memReq), .memWord(memWord), .configSpace(configSpace),
    .readBusy(readBusy));
  program_memory_model mem_u (.clock(clock), .memReq(memReq), .memWord(memWord));
  // Clock and activity counters
  initial begin
    forever #2 clock = ~clock;
  end
  always @(posedge clock) begin
    if (readBusy === 1'b1) busyCycles++;
    if (memReq.readEn === 1'b1) readEns++;
  end
  // Pointer step inside the low field only
  function automatic logic [21:0] step(logic [21:0] v, logic up);
    return {v[21], up ? v[20:0] + 21'h1 : v[20:0] - 21'h1};
  endfunction
  // Byte expected from the memory model
  function automatic logic [7:0] byteOf(logic [21:0] v);
    logic [15:0] w;
    w = {v[8:1] ^ 8'h5A, v[16:9] ^ v[21:14]};
    return v[0] ? w[15:8] : w[7:0];
  endfunction
  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer, then one idle cycle
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    lastReq = memReq;
    lastErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    if (n >= 50) begin
      miscompares++;
      $display("ERROR %0t: no pready", $time);
      give_verdict();
    end
  endtask
  task automatic setPtr(input logic [21:0] v);
    apb(1'b1, tbl_pkg::PtrLowAddr, {24'h0, v[7:0]});
    apb(1'b1, tbl_pkg::PtrHighAddr, {24'h0, v[15:8]});
    apb(1'b1, tbl_pkg::PtrUpperAddr, {26'h0, v[21:16]});
  endtask
  task automatic getPtr(output logic [21:0] v);
    apb(1'b0, tbl_pkg::PtrLowAddr, 32'h0);
    v[7:0] = r[7:0];
    apb(1'b0, tbl_pkg::PtrHighAddr, 32'h0);
    v[15:8] = r[7:0];
    apb(1'b0, tbl_pkg::PtrUpperAddr, 32'h0);
    v[21:16] = r[5:0];
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, corner_addr[i], 32'h0);
      `CHK(r, 32'h0)
    end
    for (int i = 0; i < 24; i++) begin
      p = (i < 4) ? corner[i] : 22'($random(seed));
      b = 8'($random(seed));
      setPtr(p);
      apb(1'b1, tbl_pkg::LatchAddr, {24'h0, b});
      apb(1'b1, tbl_pkg::CommandAddr, {27'h0, 1'b1, 1'b0, i[2], i[1:0]});
      a = (i[1:0] == 2'd3) ? step(p, 1'b1) : p;
      if (i[2] == 1'b0) begin
        `CHK(lastReq.readAddr, a)
        apb(1'b0, tbl_pkg::LatchAddr, 32'h0);
        `CHK(r[7:0], byteOf(a))
      end else begin
        `CHK(lastReq.holdWrEn, 1'b1)
        `CHK({lastReq.holdSel, lastReq.holdData}, {a[2:0], b})
        `CHK({lastReq.writeBlock, lastReq.eraseBlock}, {p[21:3], p[21:6]})
      end
      getPtr(q);
      `CHK(q, (i[1:0] == 2'd0) ? p : step(p, i[1:0] != 2'd2))
      `CHK(configSpace, p[21])
    end
    setPtr(22'h200003);
    b0 = busyCycles;
    e0 = readEns;
    apb(1'b1, tbl_pkg::ControlAddr, 32'h1);
    @(posedge clock);
    `CHK(busyCycles - b0, 1)
    `CHK(readEns - e0, 1)
    apb(1'b0, tbl_pkg::LatchAddr, 32'h0);
    `CHK(r[7:0], byteOf(22'h200003))
    apb(1'b1, tbl_pkg::ControlAddr, 32'h81);
    apb(1'b0, tbl_pkg::ControlAddr, 32'h0);
    `CHK(r[7:0], 8'h80)
    `CHK(busyCycles - b0, 1)
    apb(1'b1, tbl_pkg::ControlAddr, 32'h1);
    apb(1'b0, tbl_pkg::ControlAddr, 32'h0);
    `CHK(r[7:0], 8'h00)
    `CHK(busyCycles - b0, 1)
    apb(1'b1, tbl_pkg::ControlAddr, 32'h1);
    @(posedge clock);
    `CHK(busyCycles - b0, 2)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({lastErr, r}, {1'b1, 32'h0})
    give_verdict();
  end
endmodule
